//--- spfc_map.svh
// Register offsets, field positions, reset values and timing counts for the serial format block
`ifndef SPFC_MAP_SVH
`define SPFC_MAP_SVH

// Register indices on the plain register port
`define SPFC_ADDR_FORMAT 4'h0
`define SPFC_ADDR_STATION 4'h1
`define SPFC_ADDR_TIMEOUT 4'h2
`define SPFC_ADDR_CONTROL 4'h3
`define SPFC_ADDR_ACTIVE 4'h4
`define SPFC_ADDR_IRQ_STATUS 4'h5
`define SPFC_ADDR_IRQ_CLEAR 4'h6
`define SPFC_ADDR_IRQ_ENABLE 4'h7
`define SPFC_ADDR_REQUEST 4'h8

// Control register bits
`define SPFC_CTL_HOLD 0
`define SPFC_CTL_RTU 1
`define SPFC_CTL_MASTER 2
`define SPFC_CTL_RUN 3

// Request register bits
`define SPFC_REQ_READ 0
`define SPFC_REQ_WRITE 1
`define SPFC_REQ_READ_WRITE 2

// Interrupt status bits
`define SPFC_IRQ_TIMEOUT 0
`define SPFC_IRQ_APPLIED 1
`define SPFC_IRQ_REJECTED 2
`define SPFC_IRQ_RESPONSE 3

// Format word fields and reset values
`define SPFC_FMT_USED_MASK 16'h07FF
`define SPFC_FMT_DEFAULT 16'h0086
`define SPFC_RATE_DEFAULT 4'h8
`define SPFC_STATION_DEFAULT 16'h0001
`define SPFC_TIMEOUT_DEFAULT 16'h0000

// One timeout unit of ten microseconds at the 100 MHz system clock; the 16-bit
// setting still reaches about 655 ms, plenty for a slow remote station
`define SPFC_TIMEOUT_UNIT_NS 10000
`define SPFC_CLK_PERIOD_NS 10
`define SPFC_TIMEOUT_UNIT_CYC (`SPFC_TIMEOUT_UNIT_NS / `SPFC_CLK_PERIOD_NS)

`endif

//--- spfc_pkg.sv
// Types shared by the serial format block
`default_nettype none
package spfc_pkg;

  typedef enum logic [1:0] {
    SPFC_PAR_NONE = 2'b00,
    SPFC_PAR_ODD = 2'b01,
    SPFC_PAR_BAD = 2'b10,
    SPFC_PAR_EVEN = 2'b11
  } spfc_parity_e;

  typedef struct packed {
    logic eight_bits;
    spfc_parity_e parity;
    logic two_stops;
    logic [3:0] rate_code;
    logic rtu;
  } spfc_format_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spfc_bus_s;

  typedef enum logic [1:0] {
    SPFC_XFER_IDLE = 2'b00,
    SPFC_XFER_WAIT = 2'b01
  } spfc_xfer_e;

endpackage
`default_nettype wire

//--- spfc_format_check.sv
// Validates a format word and framing bit into a decoded line format
`default_nettype none
`include "spfc_map.svh"
module spfc_format_check
  import spfc_pkg::*;
(
  input wire logic [15:0] fmt_word,
  input wire logic rtu_sel,
  output spfc_format_s fmt,
  output logic valid
);

  function automatic logic rate_ok(input logic [3:0] code);
    rate_ok = (code >= 4'h1) && (code <= 4'hC) && (code != 4'h4);
  endfunction

  logic [15:0] used;

  always_comb
  begin
    used = fmt_word & `SPFC_FMT_USED_MASK;
    fmt.eight_bits = used[0];
    fmt.parity = spfc_parity_e'(used[2:1]);
    fmt.two_stops = used[3];
    fmt.rate_code = used[7:4];
    fmt.rtu = rtu_sel;
    // RTU with seven data bits is refused so the old format stays
    valid = rate_ok(used[7:4]) && (used[2:1] != 2'b10) && !(rtu_sel && !used[0]);
  end

endmodule
`default_nettype wire

//--- spfc_timeout.sv
// Response timer counting timeout units while a master request waits
`default_nettype none
`include "spfc_map.svh"
module spfc_timeout
  import spfc_pkg::*;
#(
  parameter int unsigned UNIT_CYC = `SPFC_TIMEOUT_UNIT_CYC
)
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] limit,
  output logic expired
);

  typedef struct packed {
    logic busy;
    logic [23:0] pre;
    logic [15:0] units;
    logic expired;
  } spfc_tmo_s;

  spfc_tmo_s st_ff;
  spfc_tmo_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.expired = 1'b0;
    if (start)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.pre = 24'h000000;
      nxt_st.units = 16'h0000;
    end
    else if (stop)
    begin
      nxt_st.busy = 1'b0;
    end
    else if (st_ff.busy)
    begin
      if (st_ff.pre == 24'(UNIT_CYC - 1))
      begin
        nxt_st.pre = 24'h000000;
        nxt_st.units = st_ff.units + 16'h0001;
        // A zero limit disables the timer
        if ((limit != 16'h0000) && (st_ff.units + 16'h0001 >= limit))
        begin
          nxt_st.busy = 1'b0;
          nxt_st.expired = 1'b1;
        end
      end
      else
      begin
        nxt_st.pre = st_ff.pre + 24'h000001;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign expired = st_ff.expired;

endmodule
`default_nettype wire

//--- spfc_top.sv
// Serial port format configuration registers and master request sequencing
`default_nettype none
`include "spfc_map.svh"
// Overview of operation
// - Format bit 0 picks seven or eight data bits.
// - Bits 2:1 pick parity none, odd or even; bit 3 picks stop bits.
// - Bits 7:4 pick the line rate code from 110 to 115200 baud.
// - RTU framing always uses eight data bits; seven is refused.
// - A framing bit selects ASCII when clear, RTU when set.
// - On the first scan after run starts, hold flag set applies the format.
// - A programmable timeout sets a timeout flag when no response arrives.
// - An applied format stays in effect when the program stops.
// - Power-up gives the default: 9600 baud, seven bits, even parity, one stop.
// - Slave needs only the format; master launches each request by instruction.
module spfc_top
  import spfc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic RESP_IN,
  output logic [3:0] RATE_CODE,
  output logic EIGHT_BITS,
  output logic [1:0] PARITY,
  output logic TWO_STOPS,
  output logic RTU_MODE,
  output logic MASTER_MODE,
  output logic REQ_READ,
  output logic REQ_WRITE,
  output logic REQ_READ_WRITE,
  output logic RESPONSE_TIMEOUT_FLAG,
  output logic IRQ
);

  // ==========================================================
  // Register map
  // ==========================================================
  // 0 format word, 1 station address, 2 timeout in timer units (0 disables),
  // 3 control: bit 0 hold, 1 framing, 2 master, 3 run,
  // 4 active format read back as {rtu, rate, stops, parity, eight},
  // 5 sticky status, 6 write-one-to-clear, 7 enable: bit 0 timeout, 1 applied,
  //   2 refused, 3 response,
  // 8 request: write bit 0 read, 1 write, 2 read-write; read bit 0 busy, 1 timeout.
  // Unused format bits 15:11 are stored for read-back but never decoded.
  // Software only edits the stored word; the line format moves on a first scan,
  // so a half-written format never reaches the port.
  // Refused formats (RTU with seven bits, parity 10, undefined rate codes)
  // leave the port as it was, trading a silent fallback for a status bit.

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    // Software registers
    logic [15:0] serial_format_word;
    logic [15:0] slave_station_address;
    logic [15:0] response_timeout_setting;
    // Hold flag and framing bit only matter on a first scan
    logic format_hold_flag;
    logic framing_select_bit;
    logic master;
    // Run tracking for the first-scan apply
    logic run;
    logic run_seen;
    // Format the port uses now
    spfc_format_s active;
    // Interrupt sources and mask
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    // Master request in flight
    spfc_xfer_e xfer;
    logic [2:0] req;
    logic response_timeout_flag;
    // Output registers and the response line synchroniser
    logic [15:0] rdata;
    logic irq;
    logic resp_s1;
    logic resp_s2;
  } spfc_state_s;

  spfc_state_s st_ff;
  spfc_state_s nxt_st;
  spfc_bus_s bus;
  // Decoded view of the stored word and its refusal check
  spfc_format_s cand;
  logic cand_ok;
  logic tmo_hit;
  // Strobes worked out inside the next-state process
  logic launch;
  logic first_scan;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Active format as software reads it back: {rtu, rate, stops, parity, eight}
  function automatic logic [15:0] pack_active(input spfc_format_s f);
    pack_active = {7'h00, f.rtu, f.rate_code, f.two_stops, f.parity, f.eight_bits};
  endfunction

  // Read-back mux; write-only and unmapped indices read as zero
  function automatic logic [15:0] read_word(input spfc_state_s s, input logic [3:0] a);
    case (a)
      `SPFC_ADDR_FORMAT: read_word = s.serial_format_word;
      `SPFC_ADDR_STATION: read_word = s.slave_station_address;
      `SPFC_ADDR_TIMEOUT: read_word = s.response_timeout_setting;
      `SPFC_ADDR_CONTROL:
        read_word = {12'h000, s.run, s.master, s.framing_select_bit, s.format_hold_flag};
      `SPFC_ADDR_ACTIVE: read_word = pack_active(s.active);
      `SPFC_ADDR_IRQ_STATUS: read_word = {12'h000, s.irq_status};
      `SPFC_ADDR_IRQ_ENABLE: read_word = {12'h000, s.irq_enable};
      `SPFC_ADDR_REQUEST:
        read_word = {14'h0000, s.response_timeout_flag, s.xfer == SPFC_XFER_WAIT};
      default: read_word = 16'h0000;
    endcase
  endfunction

  // A request starts only from an idle master and must name an instruction
  function automatic logic launch_ok(input spfc_state_s s, input logic [2:0] kind);
    launch_ok = s.master && (s.xfer == SPFC_XFER_IDLE) && (kind != 3'b000);
  endfunction

  // Level interrupt from sticky status gated by the enable mask
  function automatic logic irq_pending(input logic [3:0] status, input logic [3:0] enable);
    irq_pending = |(status & enable);
  endfunction

  // ==========================================================
  // Bus view, format check and response timer
  // ==========================================================

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  spfc_format_check u_check (
    .fmt_word(st_ff.serial_format_word),
    .rtu_sel(st_ff.framing_select_bit),
    .fmt(cand),
    .valid(cand_ok)
  );

  // The timer stops on the synchronised response, never on the raw line
  spfc_timeout u_tmo (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .start(launch),
    .stop(st_ff.resp_s2),
    .limit(st_ff.response_timeout_setting),
    .expired(tmo_hit)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    nxt_st = st_ff;
    // Request strobes last one cycle unless a launch sets them again
    nxt_st.req = 3'b000;
    nxt_st.resp_s1 = RESP_IN;
    nxt_st.resp_s2 = st_ff.resp_s1;
    launch = 1'b0;
    // Rising run marks the first scan; the hold flag is tested only then
    first_scan = st_ff.run && !st_ff.run_seen;
    nxt_st.run_seen = st_ff.run;

    // ==========================================================
    // Register writes
    // ==========================================================
    if (bus.wr)
    begin
      case (bus.addr)
        `SPFC_ADDR_FORMAT: nxt_st.serial_format_word = bus.wdata;
        `SPFC_ADDR_STATION: nxt_st.slave_station_address = bus.wdata;
        `SPFC_ADDR_TIMEOUT: nxt_st.response_timeout_setting = bus.wdata;
        `SPFC_ADDR_CONTROL:
        begin
          nxt_st.format_hold_flag = bus.wdata[`SPFC_CTL_HOLD];
          nxt_st.framing_select_bit = bus.wdata[`SPFC_CTL_RTU];
          nxt_st.master = bus.wdata[`SPFC_CTL_MASTER];
          // Stopping leaves the active format untouched
          nxt_st.run = bus.wdata[`SPFC_CTL_RUN];
          // Clearing run rearms the first scan for the next start
          if (bus.wdata[`SPFC_CTL_RUN] == 1'b0)
            nxt_st.run_seen = 1'b0;
        end
        `SPFC_ADDR_IRQ_CLEAR: nxt_st.irq_status = st_ff.irq_status & ~bus.wdata[3:0];
        `SPFC_ADDR_IRQ_ENABLE: nxt_st.irq_enable = bus.wdata[3:0];
        `SPFC_ADDR_REQUEST:
        begin
          // Slave mode ignores requests; master idle launches one
          if (launch_ok(st_ff, bus.wdata[2:0]))
          begin
            nxt_st.req = bus.wdata[2:0];
            nxt_st.xfer = SPFC_XFER_WAIT;
            nxt_st.response_timeout_flag = 1'b0;
            launch = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // ==========================================================
    // First-scan apply
    // ==========================================================
    // A refused word leaves the old format in place and raises the refused status
    if (first_scan && st_ff.format_hold_flag)
    begin
      if (cand_ok)
      begin
        nxt_st.active = cand;
        nxt_st.irq_status[`SPFC_IRQ_APPLIED] = 1'b1;
      end
      else
        nxt_st.irq_status[`SPFC_IRQ_REJECTED] = 1'b1;
    end

    // ==========================================================
    // Master request in flight
    // ==========================================================
    // Only the second synchroniser stage is read, so a late edge on the line
    // cannot split the response and timeout decisions
    case (st_ff.xfer)
      SPFC_XFER_IDLE: ;
      SPFC_XFER_WAIT:
      begin
        if (st_ff.resp_s2)
        begin
          nxt_st.xfer = SPFC_XFER_IDLE;
          nxt_st.irq_status[`SPFC_IRQ_RESPONSE] = 1'b1;
        end
        else if (tmo_hit)
        begin
          nxt_st.xfer = SPFC_XFER_IDLE;
          nxt_st.response_timeout_flag = 1'b1;
          nxt_st.irq_status[`SPFC_IRQ_TIMEOUT] = 1'b1;
        end
      end
      default: nxt_st.xfer = SPFC_XFER_IDLE;
    endcase

    // ==========================================================
    // Read data and interrupt
    // ==========================================================
    // Read data stands for exactly one cycle, then returns to zero
    nxt_st.rdata = 16'h0000;
    if (bus.rd)
      nxt_st.rdata = read_word(st_ff, bus.addr);

    // Taken from the next status so a set and its interrupt land together
    nxt_st.irq = irq_pending(nxt_st.irq_status, nxt_st.irq_enable);
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Power-up restores the default format whatever was applied before
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      st_ff <= '0;
      st_ff.serial_format_word <= `SPFC_FMT_DEFAULT;
      st_ff.slave_station_address <= `SPFC_STATION_DEFAULT;
      st_ff.response_timeout_setting <= `SPFC_TIMEOUT_DEFAULT;
      st_ff.active <= '{eight_bits: 1'b0, parity: SPFC_PAR_EVEN, two_stops: 1'b0,
                        rate_code: `SPFC_RATE_DEFAULT, rtu: 1'b0};
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Read data
  assign RDATA = st_ff.rdata;

  // Line format in use
  assign RATE_CODE = st_ff.active.rate_code;
  assign EIGHT_BITS = st_ff.active.eight_bits;
  assign PARITY = st_ff.active.parity;
  assign TWO_STOPS = st_ff.active.two_stops;
  assign RTU_MODE = st_ff.active.rtu;

  // Master side
  assign MASTER_MODE = st_ff.master;
  assign REQ_READ = st_ff.req[`SPFC_REQ_READ];
  assign REQ_WRITE = st_ff.req[`SPFC_REQ_WRITE];
  assign REQ_READ_WRITE = st_ff.req[`SPFC_REQ_READ_WRITE];

  // Status
  assign RESPONSE_TIMEOUT_FLAG = st_ff.response_timeout_flag;
  assign IRQ = st_ff.irq;

endmodule
`default_nettype wire

//--- spfc_props.sv
// Port checker for the serial format block
`default_nettype none
module spfc_props (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic [3:0] RATE_CODE,
  input wire logic EIGHT_BITS,
  input wire logic [1:0] PARITY,
  input wire logic TWO_STOPS,
  input wire logic RTU_MODE,
  input wire logic MASTER_MODE,
  input wire logic REQ_READ,
  input wire logic REQ_WRITE,
  input wire logic REQ_READ_WRITE,
  input wire logic RESPONSE_TIMEOUT_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Properties
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  wire logic [2:0] req = {REQ_READ_WRITE, REQ_WRITE, REQ_READ};
  property p_pulse; req != 3'h0 |=> req == 3'h0; endproperty
  property p_cause; req != 3'h0 |-> $past(WR) && $past(ADDR) == 4'h8 && $past(MASTER_MODE)
    && $past(WDATA[2:0]) == req; endproperty
  property p_mode; $changed(MASTER_MODE) |-> $past(WR) && $past(ADDR) == 4'h3; endproperty
  property p_rtu8; RTU_MODE |-> EIGHT_BITS; endproperty
  property p_par; PARITY != 2'b10; endproperty
  property p_rate; !(RATE_CODE inside {4'h0, 4'h4, 4'hD, 4'hE, 4'hF}); endproperty
  // Apply latency stays well inside six quiet cycles
  property p_hold; !WR [*6] |=> $stable({RATE_CODE, EIGHT_BITS, PARITY, TWO_STOPS, RTU_MODE});
  endproperty
  property p_flag; $fell(RESPONSE_TIMEOUT_FLAG) |-> $past(WR) && $past(ADDR) == 4'h8;
  endproperty
  a_pulse: assert property (p_pulse) else $error("request pulse too long");
  a_cause: assert property (p_cause) else $error("request without command");
  a_mode: assert property (p_mode) else $error("master mode moved alone");
  a_rtu8: assert property (p_rtu8) else $error("rtu with seven bits");
  a_par: assert property (p_par) else $error("parity code 10 active");
  a_rate: assert property (p_rate) else $error("undefined rate active");
  a_hold: assert property (p_hold) else $error("format changed unprompted");
  a_flag: assert property (p_flag) else $error("timeout flag fell alone");
  cover property (REQ_READ_WRITE);
  cover property ($rose(RESPONSE_TIMEOUT_FLAG));
  cover property ($rose(RTU_MODE));
endmodule
`default_nettype wire

//--- spfc_remote.sv
// Remote station model answering master requests on the response line
`default_nettype none
module spfc_remote (
  input wire logic CLK_SYS,
  input wire logic req,
  input wire logic mute,
  input wire logic [3:0] delay,
  output logic RESP_IN = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_ff = 5'h00;
  always @(posedge CLK_SYS)
  begin
    RESP_IN <= 1'b0;
    // A muted station never answers, which forces the timeout path
    if (req && !mute)
      cnt_ff <= {1'b0, delay} + 5'h01;
    else if (cnt_ff != 5'h00)
    begin
      cnt_ff <= cnt_ff - 5'h01;
      RESP_IN <= (cnt_ff == 5'h01);
    end
  end
endmodule
`default_nettype wire

//--- spfc_testbench.sv
// Self-checking bench for the serial format block
`default_nettype none
`include "spfc_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, RESP_IN, EIGHT_BITS, TWO_STOPS, RTU_MODE, MASTER_MODE, IRQ;
  logic REQ_READ, REQ_WRITE, REQ_READ_WRITE, RESPONSE_TIMEOUT_FLAG;
  logic NRST = 1'b0, WR = 1'b0, RD = 1'b0, mute = 1'b0, rd_q = 1'b0;
  logic [1:0] PARITY;
  logic [3:0] ADDR = 4'h0, RATE_CODE;
  logic [15:0] WDATA = 16'h0000, RDATA, w, exp_q[$];
  logic [8:0] cur;
  logic [31:0] seed = 32'h00000029;
  logic [3:0] rates [11] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  int n_fail = 0;
  int n_checks = 0;
  spfc_top i_dut (.*);
  spfc_remote i_remote (.CLK_SYS(CLK_SYS), .req(REQ_READ | REQ_WRITE | REQ_READ_WRITE),
    .mute(mute), .delay(seed[3:0]), .RESP_IN(RESP_IN));
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // ==========================================
  // Tasks
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_fmt(input logic [8:0] e);
    chk(16'({RTU_MODE, RATE_CODE, TWO_STOPS, PARITY, EIGHT_BITS}), 16'(e));
  endtask
  // Strobes drop for a cycle so no signal is assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic apply(input logic [15:0] ctl);
    wr(`SPFC_ADDR_CONTROL, ctl & 16'h0007);
    wr(`SPFC_ADDR_CONTROL, ctl);
    repeat (6) @(posedge CLK_SYS);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Read data monitor
  always @(posedge CLK_SYS)
  begin
    if (rd_q)
      chk(RDATA, exp_q.pop_front());
    rd_q <= RD;
  end
  initial
  begin
    repeat (5000) @(posedge CLK_SYS);
    n_fail++;
    results();
  end
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (6) @(posedge CLK_SYS);
    NRST <= 1'b1;
    @(posedge CLK_SYS);
    cur = 9'h086;
    chk_fmt(cur);
    rd(`SPFC_ADDR_FORMAT, `SPFC_FMT_DEFAULT);
    rd(`SPFC_ADDR_ACTIVE, 16'h0086);
    rd(`SPFC_ADDR_STATION, `SPFC_STATION_DEFAULT);
    rd(4'hF, 16'h0000);
    foreach (rates[i])
    begin
      w = rnd();
      w[7:4] = rates[i];
      if (w[2:1] == 2'b10)
        w[2:1] = 2'b11;
      wr(`SPFC_ADDR_FORMAT, w);
      apply({12'h000, 2'b10, w[10], 1'b1});
      if (!(w[10] && !w[0]))
        cur = {w[10], w[7:0]};
      chk_fmt(cur);
    end
    wr(`SPFC_ADDR_FORMAT, 16'h0086);
    apply(16'h000B);
    chk_fmt(cur);
    rd(`SPFC_ADDR_IRQ_STATUS, 16'h0006);
    wr(`SPFC_ADDR_FORMAT, 16'h00D1);
    apply(16'h0009);
    chk_fmt(cur);
    wr(`SPFC_ADDR_FORMAT, 16'h0085);
    apply(16'h0009);
    chk_fmt(cur);
    wr(`SPFC_ADDR_FORMAT, 16'h00C3);
    apply(16'h0008);
    chk_fmt(cur);
    apply(16'h0009);
    cur = 9'h0C3;
    chk_fmt(cur);
    rd(`SPFC_ADDR_ACTIVE, 16'h00C3);
    wr(`SPFC_ADDR_CONTROL, 16'h0000);
    repeat (6) @(posedge CLK_SYS);
    chk_fmt(cur);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    @(posedge CLK_SYS);
    chk_fmt(9'h086);
    wr(`SPFC_ADDR_REQUEST, 16'h0001);
    chk(16'({REQ_READ_WRITE, REQ_WRITE, REQ_READ}), 16'h0000);
    wr(`SPFC_ADDR_CONTROL, 16'h0004);
    chk(16'(MASTER_MODE), 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      wr(`SPFC_ADDR_REQUEST, 16'(1 << k));
      chk(16'({REQ_READ_WRITE, REQ_WRITE, REQ_READ}), 16'(1 << k));
      repeat (25) @(posedge CLK_SYS);
    end
    rd(`SPFC_ADDR_IRQ_STATUS, 16'h0008);
    wr(`SPFC_ADDR_TIMEOUT, 16'h0001);
    wr(`SPFC_ADDR_IRQ_ENABLE, 16'h0001);
    mute <= 1'b1;
    wr(`SPFC_ADDR_REQUEST, 16'h0001);
    for (int t = 0; t < 1500 && IRQ !== 1'b1; t++)
      @(posedge CLK_SYS);
    chk(16'({RESPONSE_TIMEOUT_FLAG, IRQ}), 16'h0003);
    wr(`SPFC_ADDR_IRQ_ENABLE, 16'h0000);
    chk(16'(IRQ), 16'h0000);
    wr(`SPFC_ADDR_IRQ_ENABLE, 16'h0001);
    wr(`SPFC_ADDR_IRQ_CLEAR, 16'h000F);
    rd(`SPFC_ADDR_IRQ_STATUS, 16'h0000);
    mute <= 1'b0;
    wr(`SPFC_ADDR_REQUEST, 16'h0001);
    chk(16'({RESPONSE_TIMEOUT_FLAG, IRQ}), 16'h0000);
    repeat (25) @(posedge CLK_SYS);
    results();
  end
endmodule
bind spfc_top spfc_props i_props (.*);
`default_nettype wire
